/* include/mroi_regs.vh */
// register map, field positions, reset values and geometry limits
`ifndef MROI_REGS_VH
`define MROI_REGS_VH

// byte offsets on the register bus
`define MROI_A_CTRL     8'h00
`define MROI_A_STAT     8'h04
`define MROI_A_EXPO     8'h08
`define MROI_A_HSPAN    8'h0C
`define MROI_A_VSPAN    8'h10
`define MROI_A_SHARED   8'h14
`define MROI_A_SEL      8'h18
`define MROI_A_RON      8'h1C
`define MROI_A_RY       8'h20
`define MROI_A_RX       8'h24
`define MROI_A_SIZE     8'h28

// control register bits
`define MROI_B_MULTI    0
`define MROI_B_VAR2     1
`define MROI_B_COLSKIP  2
`define MROI_B_FREERUN  3
`define MROI_B_APPLY    4
`define MROI_B_SAVE     5
`define MROI_B_LOAD     6
`define MROI_B_SLOT     7

// two-field registers: low field and high field
`define MROI_F_LO       12:0
`define MROI_F_HI       28:16

// reset values
`define MROI_EXPO_RST   32'h0000_0100
`define MROI_HSPAN_RST  32'h0FFF_0000
`define MROI_VSPAN_RST  32'h0BFF_0000
`define MROI_SW_RST     13'h1000

// geometry limits, shared column variant
`define MROI_V1_SENS_W  14'h1000
`define MROI_V1_SENS_H  14'h0C00
`define MROI_V1_MIN_W   14'h0018
`define MROI_V1_MIN_YH  14'h0004
`define MROI_V1_XMASK   14'h0007
`define MROI_V1_YMASK   14'h0003

// geometry limits, per-region column variant
`define MROI_V2_SENS    14'h1400
`define MROI_V2_MIN_W   14'h0100
`define MROI_V2_XMASK   14'h003F

// bus responses
`define MROI_RESP_OK    2'b00
`define MROI_RESP_ERR   2'b10

`endif

/* hw/mroi_geom_chk.v */
// geometry check of one region descriptor against alignment and size limits
`timescale 1ns/1ps
`default_nettype none
`include "mroi_regs.vh"

module mroi_geom_chk (
  input  wire        var2,
  input  wire [12:0] off_x,
  input  wire [12:0] width,
  input  wire [12:0] off_y,
  input  wire [12:0] height,
  output wire        bad
);
  wire [13:0] x  = {1'b0, off_x};
  wire [13:0] w  = {1'b0, width};
  wire [13:0] y  = {1'b0, off_y};
  wire [13:0] h  = {1'b0, height};
  wire [13:0] xe = x + w;
  wire [13:0] ye = y + h;

  // shared column offset variant
  wire bad1 = (|(x & `MROI_V1_XMASK)) | (|(w & `MROI_V1_XMASK)) |
              (w < `MROI_V1_MIN_W) | (xe > `MROI_V1_SENS_W) |
              (|(y & `MROI_V1_YMASK)) | (|(h & `MROI_V1_YMASK)) |
              (y < `MROI_V1_MIN_YH) | (h < `MROI_V1_MIN_YH) |
              (ye > `MROI_V1_SENS_H);
  // per-region column offset variant
  wire bad2 = (|(x & `MROI_V2_XMASK)) | (|(w & `MROI_V2_XMASK)) |
              (w < `MROI_V2_MIN_W) | (xe > `MROI_V2_SENS) |
              (h == 14'h0000) | (ye > `MROI_V2_SENS);

  assign bad = var2 ? bad2 : bad1;
endmodule // mroi_geom_chk

`default_nettype wire

/* hw/mroi_readout_window.v */
// multi-region readout window: registers, readout sequencer, pixel gate
`timescale 1ns/1ps
`default_nettype none
`include "mroi_regs.vh"

module mroi_readout_window #(
  parameter          PW         = 12,
  parameter [31:0]   EXPO_RESET = `MROI_EXPO_RST
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output wire [1:0]    s_axi_bresp,
  output wire          s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output wire [31:0]   s_axi_rdata,
  output wire [1:0]    s_axi_rresp,
  output wire          s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          frame_trig,
  input  wire [PW-1:0] sen_pix_data,
  output wire          sen_rd,
  output wire [12:0]   sen_row,
  output wire [12:0]   sen_col,
  output wire          vid_valid,
  output wire [PW-1:0] vid_data,
  output wire          vid_sof,
  output wire          vid_eol,
  output wire          vid_eof,
  output wire          strobe_out
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_EXPO = 4'b0010;
  localparam [3:0] S_LOAD = 4'b0100;
  localparam [3:0] S_READ = 4'b1000;

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  reg          multi_reg, var2_reg, colskip_reg, freerun_reg, apply_req_reg;
  reg  [31:0]  expo_reg;
  reg  [12:0]  h_start_reg, h_end_reg, v_start_reg, v_end_reg;
  reg  [12:0]  pen_sx_reg, pen_sw_reg, act_sx_reg, act_sw_reg;
  reg  [4:0]   sel_reg;
  reg  [31:0]  pen_en_reg, act_en_reg;
  reg  [12:0]  pen_y_reg [0:31];
  reg  [12:0]  pen_h_reg [0:31];
  reg  [12:0]  pen_x_reg [0:31];
  reg  [12:0]  act_y_reg [0:31];
  reg  [12:0]  act_h_reg [0:31];
  reg  [12:0]  act_x_reg [0:31];
  reg  [31:0]  slot_en_reg [0:1];
  reg  [12:0]  slot_sx_reg [0:1];
  reg  [12:0]  slot_sw_reg [0:1];
  reg  [12:0]  slot_y_reg [0:63];
  reg  [12:0]  slot_h_reg [0:63];
  reg  [12:0]  slot_x_reg [0:63];

  reg  [3:0]   state_reg;
  reg          geom_err_reg;
  reg  [17:0]  sum_h;
  wire         geom_bad;
  wire [12:0]  img_w;
  wire [17:0]  img_h;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  reg          aw_full_reg, w_full_reg, awready_reg, wready_reg;
  reg          bvalid_reg, arready_reg, rvalid_reg;
  reg  [7:0]   aw_addr_reg;
  reg  [31:0]  w_data_reg, rdata_reg;
  reg  [3:0]   w_strb_reg;
  reg  [1:0]   bresp_reg, rresp_reg;

  function addr_ok(input [7:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a <= `MROI_A_SIZE);
  endfunction

  function [31:0] rd_word(input [7:0] a);
    case (a)
      `MROI_A_CTRL:   rd_word = {28'h0000000, freerun_reg, colskip_reg,
                                 var2_reg, multi_reg};
      `MROI_A_STAT:   rd_word = {29'h0, apply_req_reg, geom_err_reg,
                                 ~state_reg[0]};
      `MROI_A_EXPO:   rd_word = expo_reg;
      `MROI_A_HSPAN:  rd_word = {3'h0, h_end_reg, 3'h0, h_start_reg};
      `MROI_A_VSPAN:  rd_word = {3'h0, v_end_reg, 3'h0, v_start_reg};
      `MROI_A_SHARED: rd_word = {3'h0, pen_sw_reg, 3'h0, pen_sx_reg};
      `MROI_A_SEL:    rd_word = {27'h0, sel_reg};
      `MROI_A_RON:    rd_word = {31'h0, pen_en_reg[sel_reg]};
      `MROI_A_RY:     rd_word = {3'h0, pen_h_reg[sel_reg], 3'h0,
                                 pen_y_reg[sel_reg]};
      `MROI_A_RX:     rd_word = {19'h0, pen_x_reg[sel_reg]};
      `MROI_A_SIZE:   rd_word = {img_h, 1'b0, img_w};
      default:        rd_word = 32'h0000_0000;
    endcase
  endfunction

  wire wr_do   = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire aw_full_next = ~wr_do & (aw_full_reg | (s_axi_awvalid & awready_reg));
  wire w_full_next  = ~wr_do & (w_full_reg | (s_axi_wvalid & wready_reg));
  wire rd_take = s_axi_arvalid & arready_reg;
  wire rvalid_next  = rvalid_reg ? ~s_axi_rready : rd_take;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      rvalid_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bresp_reg   <= `MROI_RESP_OK;
      rresp_reg   <= `MROI_RESP_OK;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= ~aw_full_next;
      wready_reg  <= ~w_full_next;
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (s_axi_awvalid & awready_reg)
        aw_addr_reg <= s_axi_awaddr;
      if (s_axi_wvalid & wready_reg) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= addr_ok(aw_addr_reg) ? `MROI_RESP_OK : `MROI_RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_take) begin
        rdata_reg <= addr_ok(s_axi_araddr) ? rd_word(s_axi_araddr) :
                     32'h0000_0000;
        rresp_reg <= addr_ok(s_axi_araddr) ? `MROI_RESP_OK : `MROI_RESP_ERR;
      end
    end
  end

  wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                       {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [31:0] wval  = (rd_word(aw_addr_reg) & ~wmask) | (w_data_reg & wmask);
  wire wr_ctrl   = wr_do & (aw_addr_reg == `MROI_A_CTRL);
  wire wr_expo   = wr_do & (aw_addr_reg == `MROI_A_EXPO);
  wire wr_hspan  = wr_do & (aw_addr_reg == `MROI_A_HSPAN);
  wire wr_vspan  = wr_do & (aw_addr_reg == `MROI_A_VSPAN);
  wire wr_shared = wr_do & (aw_addr_reg == `MROI_A_SHARED);
  wire wr_sel    = wr_do & (aw_addr_reg == `MROI_A_SEL);
  wire wr_ron    = wr_do & (aw_addr_reg == `MROI_A_RON);
  wire wr_ry     = wr_do & (aw_addr_reg == `MROI_A_RY);
  wire wr_rx     = wr_do & (aw_addr_reg == `MROI_A_RX);
  wire slot      = wval[`MROI_B_SLOT];

  ////////////////////////////////////////////////////////////////////////////
  // pending settings and user storage slots
  wire idle     = state_reg[0];
  wire act_load = idle & (apply_req_reg | ~var2_reg);
  integer i, j, k;
  wire [31:0] hspan_rst = `MROI_HSPAN_RST;
  wire [31:0] vspan_rst = `MROI_VSPAN_RST;

  always @(posedge aclk) begin
    if (!aresetn) begin
      multi_reg     <= 1'b0;
      var2_reg      <= 1'b0;
      colskip_reg   <= 1'b0;
      freerun_reg   <= 1'b0;
      apply_req_reg <= 1'b0;
      expo_reg      <= EXPO_RESET;
      h_start_reg   <= hspan_rst[`MROI_F_LO];
      h_end_reg     <= hspan_rst[`MROI_F_HI];
      v_start_reg   <= vspan_rst[`MROI_F_LO];
      v_end_reg     <= vspan_rst[`MROI_F_HI];
      pen_sx_reg    <= 13'h0000;
      pen_sw_reg    <= `MROI_SW_RST;
      sel_reg       <= 5'h00;
      pen_en_reg    <= 32'h0000_0000;
      for (i = 0; i < 2; i = i + 1) begin
        slot_en_reg[i] <= 32'h0000_0000;
        slot_sx_reg[i] <= 13'h0000;
        slot_sw_reg[i] <= `MROI_SW_RST;
      end
      for (i = 0; i < 32; i = i + 1) begin
        pen_y_reg[i] <= 13'h0000;
        pen_h_reg[i] <= 13'h0000;
        pen_x_reg[i] <= 13'h0000;
      end
      for (i = 0; i < 64; i = i + 1) begin
        slot_y_reg[i] <= 13'h0000;
        slot_h_reg[i] <= 13'h0000;
        slot_x_reg[i] <= 13'h0000;
      end
    end else begin
      // a new apply in the cycle of the copy wins over the clear
      if (act_load)
        apply_req_reg <= 1'b0;
      if (wr_ctrl) begin
        multi_reg   <= wval[`MROI_B_MULTI];
        var2_reg    <= wval[`MROI_B_VAR2];
        colskip_reg <= wval[`MROI_B_COLSKIP];
        freerun_reg <= wval[`MROI_B_FREERUN];
        if (wval[`MROI_B_APPLY])
          apply_req_reg <= 1'b1;
        if (wval[`MROI_B_SAVE]) begin
          slot_en_reg[slot] <= pen_en_reg;
          slot_sx_reg[slot] <= pen_sx_reg;
          slot_sw_reg[slot] <= pen_sw_reg;
          for (i = 0; i < 32; i = i + 1) begin
            slot_y_reg[slot * 32 + i] <= pen_y_reg[i];
            slot_h_reg[slot * 32 + i] <= pen_h_reg[i];
            slot_x_reg[slot * 32 + i] <= pen_x_reg[i];
          end
        end else if (wval[`MROI_B_LOAD]) begin
          pen_en_reg <= slot_en_reg[slot];
          pen_sx_reg <= slot_sx_reg[slot];
          pen_sw_reg <= slot_sw_reg[slot];
          for (i = 0; i < 32; i = i + 1) begin
            pen_y_reg[i] <= slot_y_reg[slot * 32 + i];
            pen_h_reg[i] <= slot_h_reg[slot * 32 + i];
            pen_x_reg[i] <= slot_x_reg[slot * 32 + i];
          end
        end
      end
      if (wr_expo)
        expo_reg <= wval;
      if (wr_hspan) begin
        h_start_reg <= wval[`MROI_F_LO];
        h_end_reg   <= wval[`MROI_F_HI];
      end
      if (wr_vspan) begin
        v_start_reg <= wval[`MROI_F_LO];
        v_end_reg   <= wval[`MROI_F_HI];
      end
      if (wr_shared) begin
        pen_sx_reg <= wval[`MROI_F_LO];
        pen_sw_reg <= wval[`MROI_F_HI];
      end
      if (wr_sel)
        sel_reg <= wval[4:0];
      if (wr_ron) begin
        if (wval[0])
          pen_en_reg[sel_reg] <= 1'b1;
        else
          pen_en_reg <= pen_en_reg & ~(32'hFFFF_FFFF << sel_reg);
      end
      if (wr_ry) begin
        pen_y_reg[sel_reg] <= wval[`MROI_F_LO];
        pen_h_reg[sel_reg] <= wval[`MROI_F_HI];
      end
      if (wr_rx)
        pen_x_reg[sel_reg] <= wval[12:0];
    end
  end

  // active copy used by the sequencer, only swapped between frames
  always @(posedge aclk) begin
    if (!aresetn) begin
      act_en_reg <= 32'h0000_0000;
      act_sx_reg <= 13'h0000;
      act_sw_reg <= `MROI_SW_RST;
      for (j = 0; j < 32; j = j + 1) begin
        act_y_reg[j] <= 13'h0000;
        act_h_reg[j] <= 13'h0000;
        act_x_reg[j] <= 13'h0000;
      end
    end else if (act_load) begin
      act_en_reg <= pen_en_reg;
      act_sx_reg <= pen_sx_reg;
      act_sw_reg <= pen_sw_reg;
      for (j = 0; j < 32; j = j + 1) begin
        act_y_reg[j] <= pen_y_reg[j];
        act_h_reg[j] <= pen_h_reg[j];
        act_x_reg[j] <= pen_x_reg[j];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // geometry check and image size
  wire [31:0] reg_bad;
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_chk
      mroi_geom_chk u_chk (
        .var2   (var2_reg),
        .off_x  (var2_reg ? act_x_reg[g] : act_sx_reg),
        .width  (act_sw_reg),
        .off_y  (act_y_reg[g]),
        .height (act_h_reg[g]),
        .bad    (reg_bad[g])
      );
    end
  endgenerate

  wire single_bad = (h_start_reg > h_end_reg) | (v_start_reg > v_end_reg);
  assign geom_bad = multi_reg ? ((|(reg_bad & act_en_reg)) | ~act_en_reg[0])
                              : single_bad;

  always @* begin
    sum_h = 18'h00000;
    for (k = 0; k < 32; k = k + 1)
      if (act_en_reg[k])
        sum_h = sum_h + {5'h00, act_h_reg[k]};
  end
  assign img_w = multi_reg ? act_sw_reg : (h_end_reg - h_start_reg + 13'h0001);
  assign img_h = multi_reg ? sum_h
                           : {5'h00, v_end_reg - v_start_reg + 13'h0001};

  always @(posedge aclk) begin
    if (!aresetn)
      geom_err_reg <= 1'b0;
    else
      geom_err_reg <= geom_bad;
  end

  ////////////////////////////////////////////////////////////////////////////
  // readout sequencer
  reg  [31:0]  cnt_reg;
  reg  [4:0]   idx_reg;
  reg  [12:0]  row_reg, col_reg, rows_left_reg;
  reg          strobe_reg, sof_pend_reg;
  reg          t1_keep_reg, t1_sof_reg, t1_eol_reg, t1_eof_reg;
  reg          vid_valid_reg, vid_sof_reg, vid_eol_reg, vid_eof_reg;
  reg  [PW-1:0] vid_data_reg;

  wire [4:0]  idx_p1  = idx_reg + 5'h01;
  wire [12:0] cur_x0  = ~multi_reg ? h_start_reg :
                        (var2_reg ? act_x_reg[idx_reg] : act_sx_reg);
  wire [12:0] cur_w   = ~multi_reg ? (h_end_reg - h_start_reg + 13'h0001)
                                   : act_sw_reg;
  wire [12:0] cur_y0  = ~multi_reg ? v_start_reg : act_y_reg[idx_reg];
  wire [12:0] cur_h   = ~multi_reg ? (v_end_reg - v_start_reg + 13'h0001)
                                   : act_h_reg[idx_reg];
  wire [12:0] cur_xl  = cur_x0 + cur_w - 13'h0001;
  wire [13:0] sens_w  = var2_reg ? `MROI_V2_SENS : `MROI_V1_SENS_W;
  wire [13:0] sens_wl = sens_w - 14'h0001;
  wire [12:0] scan_first = colskip_reg ? cur_x0 : 13'h0000;
  wire [12:0] scan_last  = colskip_reg ? cur_xl : sens_wl[12:0];
  wire        reading = state_reg[3];
  wire        keep = reading & (col_reg >= cur_x0) & (col_reg <= cur_xl);
  wire        last_region = ~multi_reg | (idx_reg == 5'h1F) |
                            ~act_en_reg[idx_p1];
  wire        row_end = (col_reg == cur_xl);
  wire        start = (frame_trig | freerun_reg) & ~geom_bad &
                      ~apply_req_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= S_IDLE;
      cnt_reg       <= 32'h0000_0000;
      idx_reg       <= 5'h00;
      row_reg       <= 13'h0000;
      col_reg       <= 13'h0000;
      rows_left_reg <= 13'h0000;
      strobe_reg    <= 1'b0;
      sof_pend_reg  <= 1'b0;
      t1_keep_reg   <= 1'b0;
      t1_sof_reg    <= 1'b0;
      t1_eol_reg    <= 1'b0;
      t1_eof_reg    <= 1'b0;
      vid_valid_reg <= 1'b0;
      vid_sof_reg   <= 1'b0;
      vid_eol_reg   <= 1'b0;
      vid_eof_reg   <= 1'b0;
      vid_data_reg  <= {PW{1'b0}};
    end else begin
      // two-stage tag pipe matches the sensor's one-cycle data return
      t1_keep_reg   <= keep;
      t1_sof_reg    <= keep & sof_pend_reg;
      t1_eol_reg    <= keep & row_end;
      t1_eof_reg    <= keep & row_end & (rows_left_reg == 13'h0000) &
                       last_region;
      vid_valid_reg <= t1_keep_reg;
      vid_sof_reg   <= t1_sof_reg;
      vid_eol_reg   <= t1_eol_reg;
      vid_eof_reg   <= t1_eof_reg;
      if (t1_keep_reg)
        vid_data_reg <= sen_pix_data;
      if (keep)
        sof_pend_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            state_reg    <= S_EXPO;
            cnt_reg      <= (expo_reg == 32'h0000_0000) ? 32'h0000_0000 :
                            expo_reg - 32'h0000_0001;
            strobe_reg   <= 1'b1;
            idx_reg      <= 5'h00;
            sof_pend_reg <= 1'b1;
          end
        end
        S_EXPO: begin
          if (cnt_reg == 32'h0000_0000) begin
            state_reg  <= S_LOAD;
            strobe_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
          end
        end
        S_LOAD: begin
          state_reg     <= S_READ;
          row_reg       <= cur_y0;
          col_reg       <= scan_first;
          rows_left_reg <= cur_h - 13'h0001;
        end
        S_READ: begin
          if (col_reg == scan_last) begin
            col_reg <= scan_first;
            if (rows_left_reg == 13'h0000) begin
              if (last_region) begin
                state_reg <= S_IDLE;
              end else begin
                idx_reg   <= idx_p1;
                state_reg <= S_LOAD;
              end
            end else begin
              row_reg       <= row_reg + 13'h0001;
              rows_left_reg <= rows_left_reg - 13'h0001;
            end
          end else begin
            col_reg <= col_reg + 13'h0001;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign sen_rd        = state_reg[3];
  assign sen_row       = row_reg;
  assign sen_col       = col_reg;
  assign vid_valid     = vid_valid_reg;
  assign vid_data      = vid_data_reg;
  assign vid_sof       = vid_sof_reg;
  assign vid_eol       = vid_eol_reg;
  assign vid_eof       = vid_eof_reg;
  assign strobe_out    = strobe_reg;
endmodule // mroi_readout_window

`default_nettype wire

/* dv/mroi_far_model.sv */
// pixel source and frame grabber model at the far side of the window
`timescale 1ns/1ps
`default_nettype none
module mroi_far_model (
  input  wire logic        aclk,
  input  wire logic        sen_rd,
  input  wire logic [12:0] sen_row,
  input  wire logic [12:0] sen_col,
  input  wire logic        vid_valid,
  input  wire logic        vid_sof,
  input  wire logic        vid_eol,
  input  wire logic [11:0] vid_data,
  output logic      [11:0] sen_pix_data,
  output int               pix,
  output int               eol,
  output logic      [11:0] first
);
  initial begin
    pix = 0;
    eol = 0;
    first = 12'h000;
    sen_pix_data = 12'h000;
  end
  always @(posedge aclk) begin
    // pixel value tells its own position; toggles when not addressed
    if (sen_rd)
      sen_pix_data <= {sen_row[5:0], sen_col[5:0]};
    else
      sen_pix_data <= ~sen_pix_data;
    if (vid_valid)
      pix <= pix + 1;
    if (vid_valid && vid_eol)
      eol <= eol + 1;
    if (vid_valid && vid_sof)
      first <= vid_data;
  end
endmodule // mroi_far_model
`default_nettype wire

/* dv/mroi_readout_window_monitor.sv */
// bus and video timing assertions for the readout window
`timescale 1ns/1ps
`default_nettype none
module mroi_chk_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        sen_rd,
  input wire logic        vid_valid,
  input wire logic        vid_sof,
  input wire logic        vid_eol,
  input wire logic        vid_eof,
  input wire logic        strobe_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  arready_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  awready_block_a: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("write address taken twice");
  strobe_excl_a: assert property (strobe_out |-> !sen_rd)
    else $error("strobe high during readout");
  load_gap_a: assert property ($fell(strobe_out) |=> sen_rd)
    else $error("readout not one cycle after exposure");
  pix_lag_a: assert property (vid_valid |-> $past(sen_rd, 2))
    else $error("pixel without sensor read");
  sof_valid_a: assert property (vid_sof |-> vid_valid)
    else $error("frame start without pixel");
  eof_end_a: assert property (vid_eof |-> vid_valid && vid_eol)
    else $error("frame end not on a row end");
  cover property ($rose(strobe_out));
  cover property (vid_eof);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // mroi_chk_monitor
bind mroi_readout_window mroi_chk_monitor mroi_chk_monitor_inst (.aclk,
  .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sen_rd,
  .vid_valid, .vid_sof, .vid_eol, .vid_eof, .strobe_out);
`default_nettype wire

/* dv/test_mroi_readout_window.sv */
// self-checking bench for the readout window
`timescale 1ns/1ps
`default_nettype none
module test_mroi_readout_window;
  logic        aclk, aresetn, awv, wv, bry, arv, rry, trig;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  wire         awr, wr, bv, arr, rv, srd, vv, vsof, veol, veof, strb;
  wire  [1:0]  br, rr;
  wire  [31:0] rdat;
  wire  [12:0] srow, scol;
  wire  [11:0] spix, vdat, first;
  int          pix, eol, bad_count, check_count, sc, rc, p, e, s, r;
  mroi_readout_window mroi_readout_window_inst (.aclk, .aresetn,
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .frame_trig(trig),
    .sen_pix_data(spix), .sen_rd(srd), .sen_row(srow), .sen_col(scol),
    .vid_valid(vv), .vid_data(vdat), .vid_sof(vsof), .vid_eol(veol),
    .vid_eof(veof), .strobe_out(strb));
  mroi_far_model mroi_far_model_inst (.aclk, .sen_rd(srd), .sen_row(srow),
    .sen_col(scol), .vid_valid(vv), .vid_sof(vsof), .vid_eol(veol),
    .vid_data(vdat), .sen_pix_data(spix), .pix, .eol, .first);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd32(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd = rdat;
    rry <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic shoot;
    int p0, e0, s0, r0, i;
    p0 = pix;
    e0 = eol;
    s0 = sc;
    r0 = rc;
    trig <= 1'b1;
    @(posedge aclk);
    trig <= 1'b0;
    for (i = 0; i < 3000 && !veof; i++) @(posedge aclk);
    while (srd) @(posedge aclk);
    repeat (4) @(posedge aclk);
    p = pix - p0;
    e = eol - e0;
    s = sc - s0;
    r = rc - r0;
  endtask
  task automatic t_regs;
    rd32(8'h08);
    chk(rd, 32'h0000_0100);
    chk(rr, 2'b00);
    rd32(8'h2C);
    chk({rr, rd[29:0]}, 32'h8000_0000);
    wr32(8'h2C, 32'h0000_0000);
    chk(br, 2'b10);
    $display("regs done");
  endtask
  task automatic t_single;
    wr32(8'h00, 32'h0000_0004);
    wr32(8'h08, 32'h0000_0003);
    wr32(8'h0C, 32'h0005_0002);
    wr32(8'h10, 32'h0002_0001);
    shoot();
    chk(s, 3);
    chk(p, 8);
    chk(e, 2);
    chk(first, 12'h042);
    chk(r, 8);
    wr32(8'h00, 32'h0000_0000);
    wr32(8'h10, 32'h0001_0001);
    shoot();
    chk(r, 4096);
    chk(p, 4);
    $display("single done");
  endtask
  task automatic t_multi;
    wr32(8'h00, 32'h0000_0005);
    wr32(8'h14, 32'h0018_0008);
    for (int i = 0; i < 3; i++) begin
      wr32(8'h18, i);
      wr32(8'h20, 32'h0004_0000 | (32'h8 - 4 * (i == 1) + 4 * (i == 2)));
      wr32(8'h1C, 32'h1);
    end
    rd32(8'h28);
    chk(rd, 32'h0003_0018);
    shoot();
    chk(p, 288);
    chk(e, 12);
    chk(first, 12'h208);
    wr32(8'h00, 32'h0000_0025);
    wr32(8'h18, 32'h1);
    wr32(8'h1C, 32'h0);
    wr32(8'h18, 32'h2);
    rd32(8'h1C);
    chk(rd[0], 1'b0);
    rd32(8'h28);
    chk(rd, 32'h0001_0018);
    wr32(8'h00, 32'h0000_0045);
    rd32(8'h1C);
    chk(rd[0], 1'b1);
    $display("multi done");
  endtask
  task automatic t_bad;
    wr32(8'h14, 32'h0014_0008);
    rd32(8'h04);
    chk(rd[1], 1'b1);
    shoot();
    chk(s + p, 0);
    wr32(8'h00, 32'h0000_0007);
    wr32(8'h14, 32'h0100_0000);
    rd32(8'h28);
    chk(rd, 32'h0003_0014);
    wr32(8'h00, 32'h0000_0017);
    rd32(8'h04);
    chk(rd[2:1], 2'b00);
    $display("bad and apply done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk) if (strb) sc <= sc + 1;
  always @(posedge aclk) if (srd) rc <= rc + 1;
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    {aresetn, awv, wv, bry, arv, rry, trig, awa, ara, wd} = '0;
    {bad_count, check_count} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_single();
    t_multi();
    t_bad();
    wrap_up();
  end
endmodule // test_mroi_readout_window
`default_nettype wire
